// >>> diag_status_pkg.sv
// Package for the diagnostic and status register bank.
// Assumes one clock domain and an 8-bit register port with byte offsets.
package diag_status_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PIN_LEVEL_SNAPSHOT_OFS  = 8'h53;
    localparam logic [7:0] SELFTEST_CRC_TALLY_OFS  = 8'h54;
    localparam logic [7:0] LINK_CRC_TALLY_LOW_OFS  = 8'h55;
    localparam logic [7:0] LINK_CRC_TALLY_HIGH_OFS = 8'h56;
    localparam logic [7:0] LIMIT_ALARM_FLAGS_OFS   = 8'h57;
    localparam logic [7:0] PIN0_EXTREME_OFS        = 8'h58;
    localparam logic [7:0] PIN1_EXTREME_OFS        = 8'h59;
    localparam logic [7:0] TEMP_EXTREME_OFS        = 8'h5a;
    localparam logic [7:0] BAD_PACKET_TALLY_OFS    = 8'h5c;
    localparam logic [7:0] PACKET_ERROR_FLAGS_OFS  = 8'h5d;
    localparam logic [7:0] LANE01_ERROR_FLAGS_OFS  = 8'h5e;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int PEAK_LSB   = 4;
    localparam int TROUGH_LSB = 0;
    localparam logic [2:0] PEAK_RESET   = 3'h0;
    localparam logic [2:0] TROUGH_RESET = 3'h7;
    localparam logic [7:0] TALLY_RESET  = 8'h00;
    localparam logic [7:0] FLAGS_RESET  = 8'h00;
    // Lane 1 fields sit at this offset above lane 0
    localparam int LANE1_SHIFT = 4;
    localparam int LANE_SOFT_BIT = 3;
    localparam int LANE_HARD_BIT = 2;
    localparam int LANE_CTRL_BIT = 1;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // One sensor channel: sample strobe, reading and limits
    typedef struct packed {
        logic       sample;
        logic [2:0] reading;
        logic [2:0] upper_limit;
        logic [2:0] lower_limit;
    } sensor_s;

    // Packet error events, one-cycle pulses
    typedef struct packed {
        logic short_line_flag;
        logic payload_checksum_fault;
        logic header_double_fault;
        logic header_single_fault;
    } packet_event_s;

    // Per-lane events, one-cycle pulses
    typedef struct packed {
        logic lane_sync_soft_fault;
        logic lane_sync_hard_fault;
        logic lane_hs_request_ctrl_fault;
    } lane_event_s;

endpackage

// >>> diag_status_registers.sv
// Diagnostic and status register bank: pin levels, CRC tallies, limit
// alarms with extreme capture, and CSI-2 receive error reporting.
// Assumes event inputs are one-cycle pulses on i_ref_clk, aux pins are
// asynchronous, and the register port master never waits.
//
// The address-and-strobe port was decided locally.

module diag_status_registers #(
    parameter int PIN_COUNT = 4
) (
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_sys_rst,
    input  wire logic [7:0]                    i_reg_addr,
    input  wire logic [7:0]                    i_reg_wdata,
    input  wire logic                          i_reg_wr,
    input  wire logic                          i_reg_rd,
    output logic      [7:0]                    o_reg_rdata,
    input  wire logic [PIN_COUNT-1:0]          i_aux_pin,
    input  wire logic                          i_selftest_active,
    input  wire logic                          i_crc_error,
    input  wire logic                          i_selftest_clear,
    input  wire logic                          i_link_crc_clear,
    input  wire diag_status_pkg::sensor_s      i_pin0_sensor,
    input  wire diag_status_pkg::sensor_s      i_pin1_sensor,
    input  wire diag_status_pkg::sensor_s      i_temp_sensor,
    input  wire logic                          i_bad_packet,
    input  wire diag_status_pkg::packet_event_s i_packet_event,
    input  wire diag_status_pkg::lane_event_s  i_lane0_event,
    input  wire diag_status_pkg::lane_event_s  i_lane1_event,
    output logic                               o_tally_saturated
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Saturating increment
    function automatic logic [7:0] sat_inc8(input logic [7:0] v);
        sat_inc8 = (v == 8'hff) ? v : v + 8'h01;
    endfunction

    // Read strobe aimed at one offset
    function automatic logic rd_hit(input logic [7:0] a, input logic [7:0] ofs,
                                    input logic rd);
        rd_hit = rd && (a == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync2;
    logic [PIN_COUNT-1:0] pin_sync3;
    logic [PIN_COUNT-1:0] pin_level;

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_meta  <= '0;
            pin_sync2 <= '0;
            pin_sync3 <= '0;
            pin_level <= '0;
        end else begin
            pin_meta  <= i_aux_pin;
            pin_sync2 <= pin_meta;
            pin_sync3 <= pin_sync2;
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (pin_sync2[i] == pin_sync3[i]) begin
                    pin_level[i] <= pin_sync3[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read strobes per clearing-read register
    // ------------------------------------------------------------------
    logic rd_alarm;
    logic rd_pin0;
    logic rd_pin1;
    logic rd_temp;
    logic rd_bad;
    logic rd_pkt;

    // Clearing reads
    assign rd_alarm = rd_hit(i_reg_addr, diag_status_pkg::LIMIT_ALARM_FLAGS_OFS, i_reg_rd);
    assign rd_pin0  = rd_hit(i_reg_addr, diag_status_pkg::PIN0_EXTREME_OFS, i_reg_rd);
    assign rd_pin1  = rd_hit(i_reg_addr, diag_status_pkg::PIN1_EXTREME_OFS, i_reg_rd);
    assign rd_temp  = rd_hit(i_reg_addr, diag_status_pkg::TEMP_EXTREME_OFS, i_reg_rd);
    assign rd_bad   = rd_hit(i_reg_addr, diag_status_pkg::BAD_PACKET_TALLY_OFS, i_reg_rd);
    assign rd_pkt   = rd_hit(i_reg_addr, diag_status_pkg::PACKET_ERROR_FLAGS_OFS, i_reg_rd);

    // ------------------------------------------------------------------
    // CRC tallies
    // ------------------------------------------------------------------
    logic [7:0]  selftest_crc_error_tally;
    logic [15:0] link_crc_tally;

    // Self-test tally counts only while self-test is active
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            selftest_crc_error_tally <= diag_status_pkg::TALLY_RESET;
        end else if (i_crc_error && i_selftest_active) begin
            selftest_crc_error_tally <= sat_inc8(selftest_crc_error_tally);
        end else if (i_selftest_clear) begin
            selftest_crc_error_tally <= diag_status_pkg::TALLY_RESET;
        end
    end

    // Link tally counts outside self-test, saturating
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            link_crc_tally <= {2{diag_status_pkg::TALLY_RESET}};
        end else if (i_crc_error && !i_selftest_active) begin
            if (link_crc_tally != 16'hffff) begin
                link_crc_tally <= link_crc_tally + 16'h0001;
            end
        end else if (i_link_crc_clear) begin
            link_crc_tally <= {2{diag_status_pkg::TALLY_RESET}};
        end
    end

    // ------------------------------------------------------------------
    // Limit alarms and extreme capture
    // ------------------------------------------------------------------
    logic [5:0] alarm_flags;
    logic [2:0] peak     [3];
    logic [2:0] trough   [3];
    logic [2:0] over_ev;
    logic [2:0] under_ev;
    logic [2:0] ext_rd;
    diag_status_pkg::sensor_s sensor [3];

    // Channel 0 pin 0, channel 1 pin 1, channel 2 temperature
    assign sensor[0] = i_pin0_sensor;
    assign sensor[1] = i_pin1_sensor;
    assign sensor[2] = i_temp_sensor;
    assign ext_rd    = {rd_temp, rd_pin1, rd_pin0};

    // Limit comparison on each sample
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            over_ev[c]  = sensor[c].sample && (sensor[c].reading > sensor[c].upper_limit);
            under_ev[c] = sensor[c].sample && (sensor[c].reading < sensor[c].lower_limit);
        end
    end

    // Alarm flags: an event in the reading cycle survives the clear
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            alarm_flags <= '0;
        end else begin
            for (int c = 0; c < 3; c++) begin
                alarm_flags[2*c+1] <= over_ev[c] | (alarm_flags[2*c+1] & ~rd_alarm);
                alarm_flags[2*c]   <= under_ev[c] | (alarm_flags[2*c] & ~rd_alarm);
            end
        end
    end

    // Peak and trough capture; a read restarts from the idle marker
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int c = 0; c < 3; c++) begin
                peak[c]   <= diag_status_pkg::PEAK_RESET;
                trough[c] <= diag_status_pkg::TROUGH_RESET;
            end
        end else begin
            for (int c = 0; c < 3; c++) begin
                if (over_ev[c] && (ext_rd[c] || sensor[c].reading > peak[c])) begin
                    peak[c] <= sensor[c].reading;
                end else if (ext_rd[c]) begin
                    peak[c] <= diag_status_pkg::PEAK_RESET;
                end
                if (under_ev[c] && (ext_rd[c] || sensor[c].reading < trough[c])) begin
                    trough[c] <= sensor[c].reading;
                end else if (ext_rd[c]) begin
                    trough[c] <= diag_status_pkg::TROUGH_RESET;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // CSI-2 receive errors
    // ------------------------------------------------------------------
    logic [7:0] bad_packet_tally;
    logic [3:0] packet_error_flags;
    logic [7:0] lane01_error_flags;

    // Bad packet tally, cleared by read; a packet in the reading cycle restarts it at 1
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bad_packet_tally <= diag_status_pkg::TALLY_RESET;
        end else if (i_bad_packet) begin
            bad_packet_tally <= rd_bad ? 8'h01 : sat_inc8(bad_packet_tally);
        end else if (rd_bad) begin
            bad_packet_tally <= diag_status_pkg::TALLY_RESET;
        end
    end

    // Packet error flags, sticky until read
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            packet_error_flags <= '0;
        end else begin
            packet_error_flags <= i_packet_event | (packet_error_flags & {4{~rd_pkt}});
        end
    end

    // Lane errors, sticky; no clearing path is offered
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lane01_error_flags <= diag_status_pkg::FLAGS_RESET;
        end else begin
            lane01_error_flags[diag_status_pkg::LANE_SOFT_BIT] <=
                lane01_error_flags[diag_status_pkg::LANE_SOFT_BIT] |
                i_lane0_event.lane_sync_soft_fault;
            lane01_error_flags[diag_status_pkg::LANE_HARD_BIT] <=
                lane01_error_flags[diag_status_pkg::LANE_HARD_BIT] |
                i_lane0_event.lane_sync_hard_fault;
            lane01_error_flags[diag_status_pkg::LANE_CTRL_BIT] <=
                lane01_error_flags[diag_status_pkg::LANE_CTRL_BIT] |
                i_lane0_event.lane_hs_request_ctrl_fault;
            lane01_error_flags[diag_status_pkg::LANE_SOFT_BIT + diag_status_pkg::LANE1_SHIFT] <=
                lane01_error_flags[diag_status_pkg::LANE_SOFT_BIT + diag_status_pkg::LANE1_SHIFT] |
                i_lane1_event.lane_sync_soft_fault;
            lane01_error_flags[diag_status_pkg::LANE_HARD_BIT + diag_status_pkg::LANE1_SHIFT] <=
                lane01_error_flags[diag_status_pkg::LANE_HARD_BIT + diag_status_pkg::LANE1_SHIFT] |
                i_lane1_event.lane_sync_hard_fault;
            lane01_error_flags[diag_status_pkg::LANE_CTRL_BIT + diag_status_pkg::LANE1_SHIFT] <=
                lane01_error_flags[diag_status_pkg::LANE_CTRL_BIT + diag_status_pkg::LANE1_SHIFT] |
                i_lane1_event.lane_hs_request_ctrl_fault;
            lane01_error_flags[4] <= 1'b0;
            lane01_error_flags[0] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;

    // Select the register image; unmapped offsets read zero
    always_comb begin
        next_rdata = 8'h00;
        case (i_reg_addr)
            diag_status_pkg::PIN_LEVEL_SNAPSHOT_OFS:  next_rdata = 8'(pin_level);
            diag_status_pkg::SELFTEST_CRC_TALLY_OFS:  next_rdata = selftest_crc_error_tally;
            diag_status_pkg::LINK_CRC_TALLY_LOW_OFS:  next_rdata = link_crc_tally[7:0];
            diag_status_pkg::LINK_CRC_TALLY_HIGH_OFS: next_rdata = link_crc_tally[15:8];
            diag_status_pkg::LIMIT_ALARM_FLAGS_OFS:   next_rdata = {2'b00, alarm_flags};
            diag_status_pkg::PIN0_EXTREME_OFS:        next_rdata = {1'b0, peak[0], 1'b0, trough[0]};
            diag_status_pkg::PIN1_EXTREME_OFS:        next_rdata = {1'b0, peak[1], 1'b0, trough[1]};
            diag_status_pkg::TEMP_EXTREME_OFS:        next_rdata = {1'b0, peak[2], 1'b0, trough[2]};
            diag_status_pkg::BAD_PACKET_TALLY_OFS:    next_rdata = bad_packet_tally;
            diag_status_pkg::PACKET_ERROR_FLAGS_OFS:  next_rdata = {4'h0, packet_error_flags};
            diag_status_pkg::LANE01_ERROR_FLAGS_OFS:  next_rdata = lane01_error_flags;
            default:                                  next_rdata = 8'h00;
        endcase
    end

    // Read data registered; holds zero outside the answer cycle
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= i_reg_rd ? next_rdata : 8'h00;
        end
    end

    // Saturation indicator for any tally
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_tally_saturated <= 1'b0;
        end else begin
            o_tally_saturated <= (selftest_crc_error_tally == 8'hff) ||
                                 (link_crc_tally == 16'hffff) ||
                                 (bad_packet_tally == 8'hff);
        end
    end

endmodule

// >>> diag_status_registers_checker.sv
// Checker for the diagnostic register bank: read timing and field rules.
// Assumes the one-cycle read port and one clock with async reset.
module diag_status_registers_checker (
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_sys_rst,
    input  wire logic [7:0]                     i_reg_addr,
    input  wire logic                           i_reg_rd,
    input  wire logic [7:0]                     o_reg_rdata,
    input  wire diag_status_pkg::sensor_s       i_pin0_sensor,
    input  wire diag_status_pkg::sensor_s       i_temp_sensor,
    input  wire logic                           i_bad_packet,
    input  wire diag_status_pkg::packet_event_s i_packet_event,
    input  wire diag_status_pkg::lane_event_s   i_lane1_event,
    input  wire logic                           o_tally_saturated
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    // --------------------------------------------------------------
    // Read decode helper
    // --------------------------------------------------------------
    function automatic logic rd_at(input logic [7:0] a);
        return i_reg_rd && (i_reg_addr == a);
    endfunction

    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    property p_pin_upper;
        rd_at(8'h53) |=> o_reg_rdata[7:4] == 4'h0;
    endproperty
    property p_ext_spare;
        (rd_at(8'h58) || rd_at(8'h59) || rd_at(8'h5a)) |=> !o_reg_rdata[7] && !o_reg_rdata[3];
    endproperty
    property p_lane_spare;
        rd_at(8'h5e) |=> !o_reg_rdata[4] && !o_reg_rdata[0];
    endproperty
    property p_temp_over;
        i_temp_sensor.sample && (i_temp_sensor.reading > i_temp_sensor.upper_limit)
            ##1 !rd_at(8'h57) ##1 rd_at(8'h57) |=> o_reg_rdata[5];
    endproperty
    property p_tally_clear;
        rd_at(8'h5c) && !i_bad_packet ##1 !i_bad_packet ##1 rd_at(8'h5c) |=> o_reg_rdata == 8'h00;
    endproperty
    property p_tally_race;
        i_bad_packet && rd_at(8'h5c) ##1 !i_bad_packet && !i_reg_rd ##1 rd_at(8'h5c)
            |=> o_reg_rdata == 8'h01;
    endproperty
    property p_short_line;
        i_packet_event.short_line_flag ##2 rd_at(8'h5d) |=> o_reg_rdata[3];
    endproperty
    property p_lane1_soft;
        i_lane1_event.lane_sync_soft_fault ##[1:8] rd_at(8'h5e) |=> o_reg_rdata[7];
    endproperty
    property p_trough_rearm;
        rd_at(8'h58) && !i_pin0_sensor.sample ##1 !i_pin0_sensor.sample ##1 rd_at(8'h58)
            |=> o_reg_rdata == 8'h07;
    endproperty

    // --------------------------------------------------------------
    // Assertions and covers
    // --------------------------------------------------------------
    a_pin_upper : assert property (p_pin_upper)
        else $error("pin level upper bits not zero");
    a_ext_spare : assert property (p_ext_spare)
        else $error("extreme register spare bits not zero");
    a_lane_spare : assert property (p_lane_spare)
        else $error("lane register spare bits not zero");
    a_temp_over : assert property (p_temp_over)
        else $error("temperature over flag missing");
    a_tally_clear : assert property (p_tally_clear)
        else $error("bad packet tally not cleared by read");
    a_tally_race : assert property (p_tally_race)
        else $error("bad packet lost against clearing read");
    a_short_line : assert property (p_short_line)
        else $error("short line flag missing");
    a_lane1_soft : assert property (p_lane1_soft)
        else $error("lane 1 soft fault flag missing");
    a_trough_rearm : assert property (p_trough_rearm)
        else $error("pin 0 extremes not rearmed by read");
    c_race : cover property (i_bad_packet && rd_at(8'h5c));
    c_sat : cover property (o_tally_saturated);
    c_alarm : cover property (rd_at(8'h57) ##1 o_reg_rdata != 8'h00);
endmodule

bind diag_status_registers diag_status_registers_checker diag_status_registers_checker_i (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_pin0_sensor(i_pin0_sensor),
    .i_temp_sensor(i_temp_sensor), .i_bad_packet(i_bad_packet),
    .i_packet_event(i_packet_event), .i_lane1_event(i_lane1_event),
    .o_tally_saturated(o_tally_saturated));

// >>> diag_status_registers_tb_top.sv
// Testbench for the diagnostic register bank: reads every register over
// the register port while driving pins, sensors and error events.
// Assumes the checker is bound to the design from its own file.
module diag_status_registers_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     i_ref_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_selftest_active;
    logic [7:0]               i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [3:0]               i_aux_pin;
    logic                     o_tally_saturated;
    logic [16:0]              ev;  // crc, clears, bad packet, packet, lanes, samples
    logic [2:0]               rdg [3] = '{default: 3'h0};
    logic [2:0]               seq [7] = '{3'h3, 3'h1, 3'h0, 3'h1, 3'h6, 3'h7, 3'h6};
    logic [7:0]               rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07,
                                          8'h07, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
    diag_status_pkg::sensor_s s0, s1, s2;
    int                       fails = 0, check_count = 0;

    // Sensor carriers: limits fixed at upper 5, lower 2
    assign s0 = {ev[14], rdg[0], 3'h5, 3'h2};
    assign s1 = {ev[15], rdg[1], 3'h5, 3'h2};
    assign s2 = {ev[16], rdg[2], 3'h5, 3'h2};

    diag_status_registers diag_status_registers_i (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_aux_pin(i_aux_pin),
        .i_selftest_active(i_selftest_active), .i_crc_error(ev[0]),
        .i_selftest_clear(ev[1]), .i_link_crc_clear(ev[2]), .i_pin0_sensor(s0),
        .i_pin1_sensor(s1), .i_temp_sensor(s2), .i_bad_packet(ev[3]),
        .i_packet_event(ev[7:4]), .i_lane0_event(ev[10:8]), .i_lane1_event(ev[13:11]),
        .o_tally_saturated(o_tally_saturated));

    // --------------------------------------------------------------
    // Clock and bus tasks
    // --------------------------------------------------------------
    // 250 MHz clock
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] y);
        check_count++;
        if (y !== x) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, x, y);
        end
    endtask

    // One-cycle event pulse, optionally with a read strobe beside it
    task automatic pulse(input logic [16:0] e, input logic r, input logic [7:0] a);
        @(posedge i_ref_clk);
        ev <= e;
        i_reg_rd <= r;
        i_reg_addr <= a;
        @(posedge i_ref_clk);
        ev <= '0;
        i_reg_rd <= 1'b0;
    endtask

    // Read strobe, then data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        pulse('0, 1'b1, a);
        #1;
        chk($sformatf("rdata at %h", a), x, o_reg_rdata);
    endtask

    task automatic close_out;
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        i_sys_rst = 1'b1;
        {i_reg_wr, i_reg_rd, i_selftest_active} = '0;
        {i_reg_addr, i_reg_wdata, i_aux_pin, ev} = '0;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        // Reset values, unmapped offset, then an ignored write
        for (int i = 0; i < 12; i++) rd(8'h53 + 8'(i), rv[i]);
        @(posedge i_ref_clk);
        {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, 8'h58, 8'hff};
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
        rd(8'h58, 8'h07);
        // Pin levels after the synchroniser
        for (int i = 0; i < 2; i++) begin
            i_aux_pin <= i ? 4'h5 : 4'ha;
            repeat (6) @(posedge i_ref_clk);
            rd(8'h53, i ? 8'h05 : 8'h0a);
        end
        // CRC tallies steered by self-test mode
        i_selftest_active <= 1'b1;
        repeat (3) pulse(17'h1, 1'b0, 8'h00);
        rd(8'h54, 8'h03);
        i_selftest_active <= 1'b0;
        repeat (258) pulse(17'h1, 1'b0, 8'h00);
        rd(8'h55, 8'h02);
        rd(8'h56, 8'h01);
        rd(8'h54, 8'h03);
        pulse(17'h6, 1'b0, 8'h00);
        rd(8'h54, 8'h00);
        rd(8'h56, 8'h00);
        // Bad packet tally: saturation, clear on read, race with read
        repeat (260) pulse(17'h8, 1'b0, 8'h00);
        #1;
        chk("saturated", 8'h01, {7'h0, o_tally_saturated});
        rd(8'h5c, 8'hff);
        rd(8'h5c, 8'h00);
        chk("saturated", 8'h00, {7'h0, o_tally_saturated});
        pulse(17'h8, 1'b1, 8'h5c);
        rd(8'h5c, 8'h01);
        rd(8'h5c, 8'h00);
        // Limit alarms and extreme capture, one sensor at a time
        for (int k = 0; k < 3; k++) begin
            foreach (seq[j]) begin
                rdg[k] <= seq[j];
                pulse(17'(17'h1 << (14 + k)), 1'b0, 8'h00);
            end
            rd(8'h57, 8'(8'h03 << (2 * k)));
            rd(8'h58 + 8'(k), 8'h70);
            rd(8'h58 + 8'(k), 8'h07);
            rd(8'h57, 8'h00);
        end
        // Packet error flags, each alone, then one racing its clear
        for (int b = 0; b < 4; b++) begin
            pulse(17'(17'h10 << b), 1'b0, 8'h00);
            rd(8'h5d, 8'(8'h01 << b));
            rd(8'h5d, 8'h00);
        end
        pulse(17'h80, 1'b1, 8'h5d);
        rd(8'h5d, 8'h08);
        // Lane faults accumulate and stay set
        pulse(17'h1500, 1'b0, 8'h00);
        rd(8'h5e, 8'h4a);
        pulse(17'h2a00, 1'b0, 8'h00);
        rd(8'h5e, 8'hee);
        rd(8'h5e, 8'hee);
        close_out();
    end

    // Watchdog: the tests need under 2,000 cycles, this allows 25,000
    initial begin
        #100000;
        fails++;
        close_out();
    end
endmodule
